// ### awt_interval.v
// Decodes the interval rank code into the number of prescaler ticks per wakeup.
// Purely combinational; the caller registers whatever it derives from it.
`default_nettype none
`include "awt_regs.vh"

module awt_interval (
    // Rank code
    input wire [3:0] interval_rank_code,
    // Ticks per interval, zero means no interval
    output reg [15:0] tick_target
);

// ----------------------------------------
// Rank decode
// ----------------------------------------
// Ranks 2 to 13 double per step; the top two ranks use fixed multiples
always @* begin
    case (interval_rank_code)
        4'h0: tick_target = 16'h0000;
        4'h1: tick_target = `AWT_MULT_C1;
        4'hE: tick_target = `AWT_MULT_C14;
        4'hF: tick_target = `AWT_MULT_C15;
        default: tick_target = `AWT_MULT_C1 << (interval_rank_code - 4'h1);
    endcase
end

endmodule // awt_interval

`default_nettype wire

// ### awt_regs.vh
// Register map, field positions and reset values of the wake timer.
// Assumes a 32-bit APB slave; each 8-bit register sits in the low bits of one word.
`ifndef AWT_REGS_VH
`define AWT_REGS_VH

// ----------------------------------------
// Register indices, byte address is index times four
// ----------------------------------------
`define AWT_IDX_CTRL 2'h0
`define AWT_IDX_PRESC 2'h1
`define AWT_IDX_IVL 2'h2
`define AWT_IDX_MASK 2'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AWT_BIT_FLAG 5
`define AWT_BIT_EN 4
`define AWT_BIT_MEAS 0

// ----------------------------------------
// Reset values and special codes
// ----------------------------------------
`define AWT_RST_CTRL 8'h00
`define AWT_RST_EN 1'b0
`define AWT_RST_PRESC 6'h3F
`define AWT_PRESC_HOLD 6'h3F
`define AWT_RST_IVL 4'h0
`define AWT_IVL_OFF 4'h0
`define AWT_RST_MASK 8'h00

// ----------------------------------------
// Interval multipliers for rank 1 and the two long ranks
// ----------------------------------------
`define AWT_MULT_C14 16'h2800
`define AWT_MULT_C15 16'hF000
`define AWT_MULT_C1 16'h0001

`endif

// ### awt_sync.v
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes the inputs come from pins or another clock; only stage two is read outside.
`default_nettype none

module awt_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Levels
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_reg;
reg [WIDTH-1:0] sync_reg;

// ----------------------------------------
// Capture stages
// ----------------------------------------
// First stage feeds only the second one
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        meta_reg <= {WIDTH{1'b0}};
        sync_reg <= {WIDTH{1'b0}};
    end else begin
        meta_reg <= async_in;
        sync_reg <= meta_reg;
    end
end

assign sync_out = sync_reg;

endmodule // awt_sync

`default_nettype wire

// ### awt_wake_timer.v
// Wake timer: slow-clock prescaler, interval counter, APB registers and interrupt.
// Assumes a single pclk domain; slow clocks and option strap arrive as asynchronous pins,
// while the low-power status levels come from logic on pclk.
`default_nettype none
`include "awt_regs.vh"

// Operation
// - Slow clock from RC or divided crystal
// - Counting and interrupt start at halt entry
// - Halt entry reloads counters, fresh interval
// - Prescaler frozen while code is 0x3F
// - Division factor equals code plus two
// - Rank 1: interval is factor slow periods
// - Ranks 2-13: factor times 2^(code-1)
// - Rank 14: five times 2^11 times factor
// - Rank 15: thirty times 2^11 times factor
// - Rank field bits 3:0, zero means none
// - Flag set on wakeup, read clears it
// - Enable bit wakes from halt or wait
// - Measure bit routes slow clock to capture
module awt_wake_timer #(
    parameter XTAL_DIV = 16
) (
    // APB clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [3:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Slow clock sources, asynchronous pins
    input wire internal_slow_rc_clock,
    input wire external_crystal_clock,
    input wire slow_clock_source_option,
    // Processor low-power status, pclk domain
    input wire active_halt_mode,
    input wire wait_mode,
    // Results
    output reg wakeup_request,
    output reg wake_irq,
    output reg timer_three_capture
);

// ----------------------------------------
// Declarations
// ----------------------------------------
reg wakeup_occurred_flag_reg;
reg wakeup_enable_bit_reg;
reg clock_measure_bit_reg;
reg [5:0] prescale_code_reg;
reg [3:0] interval_rank_code_reg;
reg mask_flag_reg;
reg [7:0] xtal_div_reg;
reg xtal_tick_reg;
reg slow_prev_reg;
reg xtal_prev_reg;
reg lowpower_prev_reg;
reg run_reg;
reg [5:0] pre_cnt_reg;
reg [15:0] ivl_cnt_reg;
reg read_flag_reg;
reg [7:0] rdata_next;
reg err_next;
wire [2:0] pin_sync;
wire rc_level;
wire xtal_level;
wire src_option;
wire [15:0] tick_target;
wire lowpower;
wire lowpower_entry;
wire slow_level;
wire slow_edge;
wire xtal_edge;
wire presc_stopped;
wire presc_wrap;
wire [6:0] presc_last;
wire [16:0] ivl_cnt_inc;
wire interval_done;
wire can_run;
wire acc_start;
wire acc_done;
wire [1:0] reg_idx;
wire addr_ok;

// ----------------------------------------
// Pin synchronisation and interval decode
// ----------------------------------------
awt_sync #(
    .WIDTH(3)
) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({slow_clock_source_option, external_crystal_clock, internal_slow_rc_clock}),
    .sync_out(pin_sync)
);

assign rc_level = pin_sync[0];
assign xtal_level = pin_sync[1];
assign src_option = pin_sync[2];

awt_interval u_interval (
    .interval_rank_code(interval_rank_code_reg),
    .tick_target(tick_target)
);

// ----------------------------------------
// Slow clock source
// ----------------------------------------
// Crystal clock is divided down to a slow square wave; the divider half period is
// XTAL_DIV crystal edges, so the crystal must stay well below pclk/4 to be seen
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        xtal_prev_reg <= 1'b0;
        xtal_div_reg <= 8'h00;
        xtal_tick_reg <= 1'b0;
    end else begin
        xtal_prev_reg <= xtal_level;
        if (xtal_edge) begin
            if (xtal_div_reg == XTAL_DIV[7:0] - 8'h01) begin
                xtal_div_reg <= 8'h00;
                xtal_tick_reg <= ~xtal_tick_reg;
            end else begin
                xtal_div_reg <= xtal_div_reg + 8'h01;
            end
        end
    end
end

// Edge of the synchronised crystal level; a raw pin edge could be missed or doubled
assign xtal_edge = xtal_level & ~xtal_prev_reg;
// Option strap picks the crystal path when high
assign slow_level = src_option ? xtal_tick_reg : rc_level;

// Rising edge of the chosen slow clock is the counting event
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        slow_prev_reg <= 1'b0;
    end else begin
        slow_prev_reg <= slow_level;
    end
end

assign slow_edge = slow_level & ~slow_prev_reg;

// ----------------------------------------
// Run control
// ----------------------------------------
// Counting only starts on the edge into a low-power mode, never while awake
assign lowpower = active_halt_mode | wait_mode;
assign lowpower_entry = lowpower & ~lowpower_prev_reg;
assign presc_stopped = (prescale_code_reg == `AWT_PRESC_HOLD);
assign can_run = wakeup_enable_bit_reg & (interval_rank_code_reg != `AWT_IVL_OFF) & ~presc_stopped;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        lowpower_prev_reg <= 1'b0;
        run_reg <= 1'b0;
    end else begin
        lowpower_prev_reg <= lowpower;
        if (!lowpower || !can_run) begin
            run_reg <= 1'b0;
        end else if (lowpower_entry) begin
            run_reg <= 1'b1;
        end
    end
end

// ----------------------------------------
// Prescaler and interval counter
// ----------------------------------------
// Factor is code plus two, so the last count before wrap is code plus one
assign presc_last = {1'b0, prescale_code_reg} + 7'h01;
// Gated by the live low-power level too, so no request lands in the cycle the core wakes
assign presc_wrap = run_reg & lowpower & slow_edge & ({1'b0, pre_cnt_reg} == presc_last);
assign ivl_cnt_inc = {1'b0, ivl_cnt_reg} + 17'h0_0001;
// One interval is tick_target prescaler wraps
assign interval_done = presc_wrap & (ivl_cnt_inc == {1'b0, tick_target});

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pre_cnt_reg <= 6'h00;
        ivl_cnt_reg <= 16'h0_000;
    end else if (lowpower_entry) begin
        // Every halt entry starts a brand new interval
        pre_cnt_reg <= 6'h00;
        ivl_cnt_reg <= 16'h0_000;
    end else if (run_reg && lowpower && slow_edge) begin
        if (presc_wrap) begin
            pre_cnt_reg <= 6'h00;
            if (interval_done) begin
                ivl_cnt_reg <= 16'h0_000;
            end else begin
                ivl_cnt_reg <= ivl_cnt_inc[15:0];
            end
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 6'h01;
        end
    end
end

// ----------------------------------------
// Wakeup request and measurement route
// ----------------------------------------
// Request pulses for one cycle per completed interval; the processor acts on it
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        wakeup_request <= 1'b0;
        timer_three_capture <= 1'b0;
    end else begin
        wakeup_request <= interval_done;
        timer_three_capture <= clock_measure_bit_reg & slow_level;
    end
end

// ----------------------------------------
// APB access decode
// ----------------------------------------
// One wait state: data is registered in the first access cycle, pready follows
assign acc_start = psel & penable & ~pready;
assign acc_done = psel & penable & pready;
// Low address bits must be zero; anything else is refused with pslverr
assign reg_idx = paddr[3:2];
assign addr_ok = (paddr[1:0] == 2'b00);

// Read mux; reserved bits read as zero
always @* begin
    rdata_next = 8'h00;
    err_next = 1'b0;
    if (!addr_ok) begin
        err_next = 1'b1;
    end else begin
        case (reg_idx)
            `AWT_IDX_CTRL: begin
                rdata_next[`AWT_BIT_FLAG] = wakeup_occurred_flag_reg;
                rdata_next[`AWT_BIT_EN] = wakeup_enable_bit_reg;
                rdata_next[`AWT_BIT_MEAS] = clock_measure_bit_reg;
            end
            `AWT_IDX_PRESC: begin
                rdata_next[5:0] = prescale_code_reg;
            end
            `AWT_IDX_IVL: begin
                rdata_next[3:0] = interval_rank_code_reg;
            end
            `AWT_IDX_MASK: begin
                rdata_next[`AWT_BIT_FLAG] = mask_flag_reg;
            end
            default: begin
                err_next = 1'b1;
            end
        endcase
    end
end

// Answer registers
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
        pready <= 1'b0;
        pslverr <= 1'b0;
        read_flag_reg <= 1'b0;
    end else begin
        if (acc_start) begin
            pready <= 1'b1;
            pslverr <= err_next;
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdata_next};
            // Remember whether the flag was reported, so only a seen flag is cleared
            read_flag_reg <= ~pwrite & addr_ok & (reg_idx == `AWT_IDX_CTRL) &
                             wakeup_occurred_flag_reg;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            read_flag_reg <= 1'b0;
        end
    end
end

// ----------------------------------------
// Register writes
// ----------------------------------------
// Writes land at the completing edge; flag bit ignores writes
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        wakeup_enable_bit_reg <= `AWT_RST_EN;
        clock_measure_bit_reg <= 1'b0;
        prescale_code_reg <= `AWT_RST_PRESC;
        interval_rank_code_reg <= `AWT_RST_IVL;
        mask_flag_reg <= 1'b0;
    end else if (acc_done && pwrite && addr_ok) begin
        case (reg_idx)
            `AWT_IDX_CTRL: begin
                wakeup_enable_bit_reg <= pwdata[`AWT_BIT_EN];
                clock_measure_bit_reg <= pwdata[`AWT_BIT_MEAS];
            end
            `AWT_IDX_PRESC: begin
                prescale_code_reg <= pwdata[5:0];
            end
            `AWT_IDX_IVL: begin
                interval_rank_code_reg <= pwdata[3:0];
            end
            `AWT_IDX_MASK: begin
                mask_flag_reg <= pwdata[`AWT_BIT_FLAG];
            end
            default: begin
                mask_flag_reg <= mask_flag_reg;
            end
        endcase
    end
end

// ----------------------------------------
// Wakeup flag and interrupt
// ----------------------------------------
// A new event in the clearing cycle wins, so no wakeup goes unseen
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        wakeup_occurred_flag_reg <= 1'b0;
        wake_irq <= 1'b0;
    end else begin
        if (interval_done) begin
            wakeup_occurred_flag_reg <= 1'b1;
        end else if (acc_done && read_flag_reg) begin
            wakeup_occurred_flag_reg <= 1'b0;
        end
        // Level interrupt; one cycle behind the flag since outputs are registered
        wake_irq <= wakeup_occurred_flag_reg & mask_flag_reg;
    end
end

endmodule // awt_wake_timer

`default_nettype wire

// ### awt_wake_timer_asserts.sv
// Concurrent checks on the wake timer's ports: APB timing, wakeup pulse and interrupt.
// Assumes the one-wait-state APB slave and the single pclk domain of the design.
`default_nettype none

module awt_wake_timer_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [3:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Low-power status and results
    input wire logic active_halt_mode,
    input wire logic wait_mode,
    input wire logic wakeup_request,
    input wire logic wake_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // Transfer phases
    // ----------------------------------------
    // Setup then first access cycle
    sequence apb_start;
        psel && !penable ##1 psel && penable;
    endsequence
    // Completed access
    sequence apb_done;
        psel && penable && pready;
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Exactly one wait state, then a one-cycle answer
    chk_ready_wait: assert property (apb_start |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_bad_addr: assert property (apb_done ##0 paddr[1:0] != 2'b00 |-> pslverr && prdata == '0)
        else $error("misaligned access not refused");
    chk_rdata_high: assert property (pready |-> prdata[31:8] == '0)
        else $error("upper read data not zero");
    // Wakeup only out of a low-power state, always a single pulse
    chk_req_in_halt: assert property (wakeup_request |-> $past(active_halt_mode || wait_mode))
        else $error("wakeup outside low-power state");
    chk_req_pulse: assert property (wakeup_request |=> !wakeup_request)
        else $error("wakeup request longer than one cycle");
    // Interrupt moves only after a wakeup, a read or a mask write
    chk_irq_rise: assert property ($rose(wake_irq) |-> $past(wakeup_request) || $past(pready && pwrite, 2))
        else $error("interrupt rose without cause");
    chk_irq_fall: assert property ($fell(wake_irq) |-> $past(pready, 2))
        else $error("interrupt fell without an access");
endmodule // awt_wake_timer_asserts

bind awt_wake_timer awt_wake_timer_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .active_halt_mode(active_halt_mode), .wait_mode(wait_mode), .wakeup_request(wakeup_request),
    .wake_irq(wake_irq));

`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the wake timer: register model, wakeup timing, refusals.
// Assumes the RC pin runs at a tenth of pclk; the crystal path is selected once, with the RC pin silenced.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, rc_clk, xt_clk, halt, waitm, er, xsel;
    logic [3:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, wakeup_request, wake_irq, timer_three_capture, flag_m;
    logic [7:0] m [4];
    logic [7:0] wm [4] = '{8'h11, 8'h3F, 8'h0F, 8'h20};
    int error_cnt, cmp_count, cyc, seed, code, rank, n, c, tog;

    awt_wake_timer #(.XTAL_DIV(1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .internal_slow_rc_clock(rc_clk & ~xsel), .external_crystal_clock(xt_clk), .slow_clock_source_option(xsel),
        .active_halt_mode(halt), .wait_mode(waitm), .wakeup_request(wakeup_request), .wake_irq(wake_irq),
        .timer_three_capture(timer_three_capture));

    // ----------------------------------------
    // Clocks; the RC pin is offset so its edges never meet pclk
    // ----------------------------------------
    initial begin
        pclk = 0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        rc_clk = 0;
        #25;
        forever #500 rc_clk = ~rc_clk;
    end
    initial begin
        xt_clk = 0;
        forever #270 xt_clk = ~xt_clk;
    end

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer, then an idle cycle so a following call never re-drives psel in one step
    task automatic apb(input logic [3:0] a, input logic w, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Model write: only the writable bits are kept
    task automatic wr(input int i, input logic [7:0] d);
        apb({i[1:0], 2'b00}, 1'b1, d);
        m[i] = d & wm[i];
    endtask

    // Model read: control carries the flag, which the read clears
    task automatic rdc(input int i);
        apb({i[1:0], 2'b00}, 1'b0, 8'h00);
        chk("register", rd, {24'h00_0000, m[i] | ((i == 0 && flag_m) ? 8'h20 : 8'h00)});
        if (i == 0)
            flag_m = 1'b0;
    endtask

    task automatic count_tog;
        logic p;
        tog = 0;
        repeat (5) @(posedge pclk);
        p = timer_three_capture;
        repeat (40) begin
            @(posedge pclk);
            tog += (timer_three_capture !== p);
            p = timer_three_capture;
        end
    endtask

    // Cuts a hang short
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            test_done;
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 93;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        halt = 0;
        waitm = 0;
        xsel = 0;
        flag_m = 0;
        m = '{8'h00, 8'h3F, 8'h00, 8'h00};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) rdc(i);
        apb(4'h1, 1'b0, 8'h00);
        chk("error response", er, 1'b1);
        chk("refused read", rd, '0);
        apb(4'h5, 1'b1, 8'h00);
        chk("write error response", er, 1'b1);
        rdc(1);
        wr(0, 8'hFF);
        rdc(0);
        wr(0, 8'h01);
        count_tog;
        chk("measure toggles", tog > 2, 1'b1);
        wr(0, 8'h00);
        count_tog;
        chk("measure off", tog, 0);
        // Crystal path: the RC pin is silenced, so only the divided crystal can toggle the route
        xsel <= 1'b1;
        wr(0, 8'h01);
        count_tog;
        chk("crystal measure", tog > 2, 1'b1);
        xsel <= 1'b0;
        wr(0, 8'h00);
        // Stopped prescaler, zero rank, disabled: no wakeup in the time one would take
        for (int k = 0; k < 3; k++) begin
            wr(1, k == 0 ? 8'h3F : 8'h00);
            wr(2, k == 1 ? 8'h00 : 8'h01);
            wr(0, k == 2 ? 8'h00 : 8'h10);
            halt <= 1'b1;
            c = 0;
            repeat (700) begin
                @(posedge pclk);
                c += (wakeup_request === 1'b1);
            end
            halt <= 1'b0;
            chk("refused wakeups", c, 0);
            @(posedge pclk);
        end
        // Random short intervals; ten pclk cycles per slow period
        for (int k = 0; k < 4; k++) begin
            code = $unsigned($random(seed)) % 7;
            rank = 1 + $unsigned($random(seed)) % 3;
            n = (code + 2) * (1 << (rank - 1)) * 10;
            wr(1, code[7:0]);
            wr(2, rank[7:0]);
            wr(3, (($random(seed) & 1) != 0) ? 8'h20 : 8'h00);
            wr(0, 8'h10);
            @(posedge rc_clk);
            repeat (5) @(posedge pclk);
            if (k % 2)
                waitm <= 1'b1;
            else
                halt <= 1'b1;
            c = 0;
            do begin
                @(posedge pclk);
                c++;
            end while (wakeup_request !== 1'b1 && c < 2000);
            chk("first interval", c >= n - 5 && c <= n + 3, 1'b1);
            flag_m = 1'b1;
            @(posedge pclk);
            chk("interrupt", wake_irq, m[3][5]);
            c = 1;
            do begin
                @(posedge pclk);
                c++;
            end while (wakeup_request !== 1'b1 && c < 2000);
            chk("next interval", c, n);
            halt <= 1'b0;
            waitm <= 1'b0;
            wr(0, 8'h10);
            rdc(0);
            rdc(0);
            chk("interrupt cleared", wake_irq, 1'b0);
        end
        // Wakeup no longer used: park the rank at zero
        wr(2, 8'h00);
        rdc(2);
        test_done;
    end
endmodule // tb_top

`default_nettype wire
